// ==== hdl/agu_pkg.sv ====
package agu_pkg;

    localparam int ADDR_W = 16;
    localparam int SIZE_W = 14;
    localparam int NUM_PTR = 5;
    localparam int PTR_SEL_W = 3;

    // Pointer indices as seen on the decode port.
    localparam logic [2:0] PTR_ZERO = 3'h0;
    localparam logic [2:0] PTR_ONE = 3'h1;
    localparam logic [2:0] PTR_TWO = 3'h2;
    localparam logic [2:0] PTR_THREE = 3'h3;
    localparam logic [2:0] PTR_STACK = 3'h4;

    // Modifier register layout and values.
    localparam logic [15:0] MODIFIER_RESET = 16'hffff;
    localparam int MODIFIER_MODE_LSB = 14;
    localparam int MODIFIER_MODE_MSB = 15;
    localparam logic [1:0] MODE_ZERO_ONLY = 2'h0;
    localparam logic [1:0] MODE_BOTH = 2'h2;
    localparam logic [1:0] MODE_LINEAR = 2'h3;

    // Immediate offsets.
    localparam logic [15:0] OFFSET_PLUS_ONE = 16'h0001;
    localparam logic [15:0] OFFSET_MINUS_ONE = 16'hffff;
    localparam logic [15:0] OFFSET_NONE = 16'h0000;

    // Register byte offsets on the AHB-Lite slave.
    localparam logic [7:0] REG_ADDRESS_MODIFIER = 8'h00;
    localparam logic [7:0] REG_STEP_VALUE = 8'h04;
    localparam logic [7:0] REG_POINTER_BASE = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h1c;
    localparam int STATUS_MODULO_BIT = 16;
    localparam logic [15:0] STEP_VALUE_RESET = 16'h0000;
    localparam logic [15:0] POINTER_RESET = 16'h0000;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [2:0] {
        AM_NO_UPDATE,
        AM_POST_INC,
        AM_POST_DEC,
        AM_POST_OFFSET,
        AM_INDEX_OFFSET,
        AM_INDEX_SHORT,
        AM_INDEX_LONG
    } addr_mode_t;

endpackage

// ==== hdl/agu_modulo_adder.sv ====
`timescale 1ns/1ps
module agu_modulo_adder
    import agu_pkg::*;
#(
    parameter int AW = 16,
    parameter int SW = 14
)
(
    input wire logic [AW-1:0] pointer_i,
    input wire logic [AW-1:0] offset_i,
    input wire logic [SW-1:0] size_m1_i,
    output logic [AW-1:0] result_o
);
    logic [SW-1:0] low_mask;
    logic signed [AW+1:0] low_val;
    logic signed [AW+1:0] sum;
    logic signed [AW+1:0] modulus;
    logic signed [AW+1:0] wrapped;
    logic [AW-1:0] mask_full;

    // The k-bit mask covers every bit up to the highest set bit of size-1.
    always_comb
    begin
        low_mask = size_m1_i;
        for (int i = SW - 2; i >= 0; i--)
        begin
            low_mask[i] = low_mask[i] | low_mask[i + 1];
        end
    end

    assign mask_full = {{(AW - SW){1'b0}}, low_mask};
    assign low_val = signed'({2'b00, pointer_i & mask_full});
    assign modulus = signed'({{(AW - SW + 2){1'b0}}, size_m1_i}) + 18'sd1;
    assign sum = low_val + signed'({{2{offset_i[AW-1]}}, offset_i});

    // One correction suffices because the offset never exceeds the buffer size.
    always_comb
    begin
        if (sum >= modulus)
        begin
            wrapped = sum - modulus;
        end
        else if (sum < 0)
        begin
            wrapped = sum + modulus;
        end
        else
        begin
            wrapped = sum;
        end
    end

    // Upper bits are held so the buffer stays in its address block.
    assign result_o = (pointer_i & ~mask_full) | (wrapped[AW-1:0] & mask_full);
endmodule

// ==== hdl/agu_linear_modulo_update.sv ====
`timescale 1ns/1ps
// Functional notes
// - Pointers zero and one may use modulo; two, three and stack pointer always linear.
// - Linear update is 16-bit two's-complement add of a signed offset.
// - Offset is step register, immediate +1/-1, or displacement; offset signed, address unsigned.
// - Modifier all ones selects linear arithmetic for pointers zero and one.
// - Reset loads the modifier with all ones.
// - Linear overflow wraps within 16 bits, with no error indication.
// - Post-increment and post-decrement of a modulo pointer use modulo arithmetic.
// - Passing the top wraps to base; decrementing at base wraps to top.
// - Buffer base is the pointer with its low k bits cleared.
// - Modulo update changes only the low k bits; upper bits stay.
// - New low bits are old low bits plus offset modulo size.
// - Values between size and two to the k minus one are never reached.
// - One modifier serves both pointers; pointer one modulo only with pointer zero, same size.
// - Modifier bits 15:14: 00 zero only, 10 both, 11 linear.
// - Low 14 modifier bits hold buffer size minus one, sizes 2 to 16384.
// - Modulo covers no update, post inc/dec, post offset, index offset, long displacement.
module agu_linear_modulo_update
    import agu_pkg::*;
#(
    parameter int AW = 16
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic req_valid_i,
    input wire logic [agu_pkg::PTR_SEL_W-1:0] req_ptr_i,
    input wire agu_pkg::addr_mode_t req_mode_i,
    input wire logic [AW-1:0] req_disp_i,
    output logic ea_valid_o,
    output logic [AW-1:0] ea_o,
    output logic [AW-1:0] new_ptr_o,
    output logic modulo_used_o
);
    import agu_pkg::*;

    logic [15:0] address_modifier;
    logic [AW-1:0] step_value_reg;
    logic [AW-1:0] ptr_q [NUM_PTR];

    logic wr_pend;
    logic [7:0] wr_addr;

    logic bus_take;
    logic [7:0] bus_addr;
    logic [31:0] next_rdata;

    logic req_take;
    logic [AW-1:0] sel_ptr;
    logic [AW-1:0] offset;
    logic [AW-1:0] linear_sum;
    logic [AW-1:0] modulo_sum;
    logic [AW-1:0] calc_value;
    logic [AW-1:0] next_ea;
    logic modulo_en;
    logic modulo_mode_ok;
    logic writes_back;
    logic [1:0] mode_field;

    // The clock enable stalls the bus too, so no transfer is seen while frozen.
    assign hreadyout_o = ce_i;
    assign hresp_o = HRESP_OKAY;

    assign bus_take = ce_i && hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ || htrans_i == HTRANS_SEQ);
    assign bus_addr = haddr_i[7:0];

    // Write address is held over to the data phase, where hwdata is valid.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end
        else if (ce_i)
        begin
            if (hready_i)
            begin
                wr_pend <= bus_take && hwrite_i;
                wr_addr <= bus_addr;
            end
        end
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        if (bus_addr == REG_ADDRESS_MODIFIER)
        begin
            next_rdata = {16'h0000, address_modifier};
        end
        else if (bus_addr == REG_STEP_VALUE)
        begin
            next_rdata = {{(32 - AW){1'b0}}, step_value_reg};
        end
        else if (bus_addr == REG_STATUS)
        begin
            next_rdata = {15'h0000, modulo_used_o, ea_o};
        end
        else
        begin
            for (int i = 0; i < NUM_PTR; i++)
            begin
                if (bus_addr == REG_POINTER_BASE + 8'(4 * i))
                begin
                    next_rdata = {{(32 - AW){1'b0}}, ptr_q[i]};
                end
            end
        end
    end

    // Read data is captured at the address phase and stands through the data phase.
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            hrdata_o <= 32'h0000_0000;
        end
        else if (ce_i && bus_take && !hwrite_i)
        begin
            hrdata_o <= next_rdata;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            address_modifier <= MODIFIER_RESET;
        end
        else if (ce_i && wr_pend && wr_addr == REG_ADDRESS_MODIFIER)
        begin
            address_modifier <= hwdata_i[15:0];
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            step_value_reg <= STEP_VALUE_RESET;
        end
        else if (ce_i && wr_pend && wr_addr == REG_STEP_VALUE)
        begin
            step_value_reg <= hwdata_i[AW-1:0];
        end
    end

    assign req_take = ce_i && req_valid_i && (req_ptr_i <= PTR_STACK);
    assign sel_ptr = (req_ptr_i <= PTR_STACK) ? ptr_q[req_ptr_i] : POINTER_RESET;

    always_comb
    begin
        unique case (req_mode_i)
            AM_NO_UPDATE:
            begin
                offset = OFFSET_NONE;
            end
            AM_POST_INC:
            begin
                offset = OFFSET_PLUS_ONE;
            end
            AM_POST_DEC:
            begin
                offset = OFFSET_MINUS_ONE;
            end
            AM_POST_OFFSET, AM_INDEX_OFFSET:
            begin
                offset = step_value_reg;
            end
            AM_INDEX_SHORT, AM_INDEX_LONG:
            begin
                offset = req_disp_i;
            end
            default:
            begin
                offset = OFFSET_NONE;
            end
        endcase
    end

    // Plain unsigned add; the carry out is dropped, so no overflow flag exists.
    assign linear_sum = sel_ptr + offset;

    assign mode_field = address_modifier[MODIFIER_MODE_MSB:MODIFIER_MODE_LSB];

    always_comb
    begin
        modulo_mode_ok = 1'b0;
        if (req_ptr_i == PTR_ZERO)
        begin
            modulo_mode_ok = (mode_field == MODE_ZERO_ONLY) || (mode_field == MODE_BOTH);
        end
        else if (req_ptr_i == PTR_ONE)
        begin
            modulo_mode_ok = (mode_field == MODE_BOTH);
        end
        // Pointers two, three and the stack pointer never enable modulo.
        if (address_modifier == MODIFIER_RESET)
        begin
            modulo_mode_ok = 1'b0;
        end
    end

    // Short displacement indexing is always linear.
    assign modulo_en = modulo_mode_ok && (req_mode_i != AM_INDEX_SHORT);

    agu_modulo_adder #(
        .AW(AW),
        .SW(SIZE_W)
    ) u_modulo (
        .pointer_i(sel_ptr),
        .offset_i(offset),
        .size_m1_i(address_modifier[SIZE_W-1:0]),
        .result_o(modulo_sum)
    );

    assign calc_value = modulo_en ? modulo_sum : linear_sum;

    always_comb
    begin
        unique case (req_mode_i)
            AM_POST_INC, AM_POST_DEC, AM_POST_OFFSET:
            begin
                next_ea = sel_ptr;
                writes_back = 1'b1;
            end
            AM_INDEX_OFFSET, AM_INDEX_SHORT, AM_INDEX_LONG:
            begin
                next_ea = calc_value;
                writes_back = 1'b0;
            end
            default:
            begin
                next_ea = sel_ptr;
                writes_back = 1'b0;
            end
        endcase
    end

    // Bus writes to a pointer win over an update in the same cycle.
    generate
        for (genvar p = 0; p < NUM_PTR; p++)
        begin : g_ptr
            always_ff @(posedge clk_sys_i)
            begin
                if (srst_i)
                begin
                    ptr_q[p] <= POINTER_RESET;
                end
                else if (ce_i)
                begin
                    if (wr_pend && wr_addr == REG_POINTER_BASE + 8'(4 * p))
                    begin
                        ptr_q[p] <= hwdata_i[AW-1:0];
                    end
                    else if (req_take && writes_back && req_ptr_i == PTR_SEL_W'(p))
                    begin
                        ptr_q[p] <= calc_value;
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ea_valid_o <= 1'b0;
        end
        else if (ce_i)
        begin
            ea_valid_o <= req_take;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            ea_o <= POINTER_RESET;
            new_ptr_o <= POINTER_RESET;
            modulo_used_o <= 1'b0;
        end
        else if (req_take)
        begin
            ea_o <= next_ea;
            new_ptr_o <= writes_back ? calc_value : sel_ptr;
            modulo_used_o <= modulo_en;
        end
    end

endmodule

// ==== bench/agu_update_props.sv ====
`timescale 1ns/1ps
module agu_update_props
#(
    parameter int AW = 16
)
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic req_valid_i,
    input wire logic [agu_pkg::PTR_SEL_W-1:0] req_ptr_i,
    input wire agu_pkg::addr_mode_t req_mode_i,
    input wire logic ea_valid_o,
    input wire logic [AW-1:0] ea_o,
    input wire logic [AW-1:0] new_ptr_o,
    input wire logic modulo_used_o
);
    import agu_pkg::*;
    logic taken;
    assign taken = req_valid_i && ce_i && req_ptr_i <= PTR_STACK;
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (srst_i);
    a_answer_next_cycle: assert property (taken |=> ea_valid_o)
        else $error("No update pulse after a request.");
    a_no_spurious_pulse: assert property (ce_i && !taken |=> !ea_valid_o)
        else $error("Update pulse without a request.");
    a_high_ptrs_linear: assert property (taken && req_ptr_i >= PTR_TWO |=> !modulo_used_o)
        else $error("Modulo used on a linear-only pointer.");
    a_short_index_linear: assert property (taken && req_mode_i == AM_INDEX_SHORT |=> !modulo_used_o)
        else $error("Modulo used on short displacement.");
    a_inc_linear_wrap: assert property (ea_valid_o && $past(ce_i) && !modulo_used_o &&
        $past(req_mode_i) == AM_POST_INC |-> new_ptr_o == ea_o + 16'h0001)
        else $error("Linear increment wrong.");
    a_dec_linear_sub: assert property (ea_valid_o && $past(ce_i) && !modulo_used_o &&
        $past(req_mode_i) == AM_POST_DEC |-> new_ptr_o == ea_o - 16'h0001)
        else $error("Linear decrement wrong.");
    a_no_update_keeps: assert property (ea_valid_o && $past(ce_i) &&
        $past(req_mode_i) == AM_NO_UPDATE |-> new_ptr_o == ea_o)
        else $error("Pointer moved without update.");
    a_modulo_block_kept: assert property (ea_valid_o && modulo_used_o |-> new_ptr_o[15:14] == ea_o[15:14])
        else $error("Modulo update left its block.");
    a_outputs_hold: assert property (!ea_valid_o && !$past(srst_i) |-> $stable(ea_o) && $stable(new_ptr_o))
        else $error("Outputs changed without a request.");
    c_modulo: cover property (ea_valid_o && modulo_used_o);
    c_linear: cover property (ea_valid_o && !modulo_used_o);
    c_stall: cover property (!ce_i && req_valid_i);
endmodule
bind agu_linear_modulo_update agu_update_props #(.AW(AW)) agu_update_props_inst (.clk_sys_i, .srst_i, .ce_i,
    .req_valid_i, .req_ptr_i, .req_mode_i, .ea_valid_o, .ea_o, .new_ptr_o, .modulo_used_o);

// ==== bench/agu_decode_model.sv ====
`timescale 1ns/1ps
module agu_decode_model
(
    input wire logic clk_sys_i,
    output logic req_valid_o,
    output logic [agu_pkg::PTR_SEL_W-1:0] req_ptr_o,
    output agu_pkg::addr_mode_t req_mode_o,
    output logic [15:0] req_disp_o
);
    import agu_pkg::*;
    initial
    begin
        req_valid_o = 1'b0;
        req_ptr_o = PTR_ZERO;
        req_mode_o = AM_NO_UPDATE;
        req_disp_o = 16'h0000;
    end
    // Holds the request across the edge; back-to-back calls keep valid high.
    task automatic issue(input logic [2:0] p, input addr_mode_t m, input logic [15:0] d);
        req_valid_o <= 1'b1;
        req_ptr_o <= p;
        req_mode_o <= m;
        req_disp_o <= d;
        @(posedge clk_sys_i);
    endtask
    // A stale displacement is scrambled so nothing can lean on its last value.
    task automatic idle();
        req_valid_o <= 1'b0;
        req_disp_o <= ~req_disp_o;
        @(posedge clk_sys_i);
    endtask
endmodule

// ==== bench/agu_linear_modulo_update_bench.sv ====
`timescale 1ns/1ps
module agu_linear_modulo_update_bench;
    import agu_pkg::*;
    logic clk_sys_i = 1'b0;
    logic srst_i = 1'b1;
    logic ce_i = 1'b1;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [1:0] htrans_i = 2'h0;
    logic [2:0] hsize_i = 3'h2;
    logic hreadyout_o, hresp_o, req_valid, ea_valid_o, modulo_used_o;
    logic [31:0] hrdata_o;
    logic [2:0] req_ptr;
    addr_mode_t req_mode;
    logic [15:0] req_disp, ea_o, new_ptr_o, rnd = 16'h0047;
    logic [15:0] ptrs [5] = '{default: 16'h0000};
    logic [15:0] modr = MODIFIER_RESET;
    logic [15:0] step = STEP_VALUE_RESET;
    logic [32:0] expq [$];
    int err_total = 0;
    int compares = 0;
    always #2.5 clk_sys_i = ~clk_sys_i;
    agu_linear_modulo_update agu_linear_modulo_update_inst (.clk_sys_i, .srst_i, .ce_i, .hsel_i, .haddr_i,
        .htrans_i, .hwrite_i, .hsize_i, .hwdata_i, .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o,
        .req_valid_i(req_valid), .req_ptr_i(req_ptr), .req_mode_i(req_mode), .req_disp_i(req_disp),
        .ea_valid_o, .ea_o, .new_ptr_o, .modulo_used_o);
    agu_decode_model agu_decode_model_inst (.clk_sys_i, .req_valid_o(req_valid), .req_ptr_o(req_ptr),
        .req_mode_o(req_mode), .req_disp_o(req_disp));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string n, input logic [32:0] e, input logic [32:0] g);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Lowers any pending request first so a bus access never doubles an update.
    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        agu_decode_model_inst.idle();
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        htrans_i <= HTRANS_NONSEQ;
        hwrite_i <= w;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge clk_sys_i); while (hreadyout_o !== 1'b1);
        q = hrdata_o;
        check("response", {32'h0, HRESP_OKAY}, {32'h0, hresp_o});
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [31:0] q;
        bus(a, 1'b1, {16'h0, v}, q);
        if (a == REG_ADDRESS_MODIFIER)
            modr = v;
        else if (a == REG_STEP_VALUE)
            step = v;
        else
            ptrs[(a - 8'h08) >> 2] = v;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(a, 1'b0, 32'h0, q);
        check("register", {1'b0, e}, {1'b0, q});
    endtask
    task automatic req(input logic [2:0] p, input addr_mode_t m, input logic [15:0] d);
        logic [15:0] off, calc;
        logic md;
        int sz, lo, km;
        off = m == AM_POST_INC ? OFFSET_PLUS_ONE : m == AM_POST_DEC ? OFFSET_MINUS_ONE :
            m == AM_NO_UPDATE ? OFFSET_NONE : (m == AM_POST_OFFSET || m == AM_INDEX_OFFSET) ? step : d;
        md = m != AM_INDEX_SHORT && modr != MODIFIER_RESET && ((modr[15:14] == MODE_BOTH && p <= PTR_ONE) ||
            (modr[15:14] == MODE_ZERO_ONLY && p == PTR_ZERO));
        calc = ptrs[p] + off;
        if (md)
        begin
            sz = int'(modr[13:0]) + 1;
            km = 1;
            while (km < sz) km = km * 2;
            km = km - 1;
            lo = int'(ptrs[p] & km[15:0]) + int'($signed(off));
            lo = lo >= sz ? lo - sz : lo < 0 ? lo + sz : lo;
            calc = (ptrs[p] & ~km[15:0]) | lo[15:0];
        end
        if (m >= AM_INDEX_OFFSET)
            expq.push_back({md, calc, ptrs[p]});
        else
        begin
            expq.push_back({md, ptrs[p], calc});
            ptrs[p] = calc;
        end
        agu_decode_model_inst.issue(p, m, d);
    endtask
    always @(negedge clk_sys_i)
        if (ea_valid_o === 1'b1)
            check("update", expq.size() > 0 ? expq.pop_front() : 'x, {modulo_used_o, ea_o, new_ptr_o});
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        err_total++;
        test_done();
    end
    initial
    begin
        repeat (6) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        @(posedge clk_sys_i);
        rd(REG_ADDRESS_MODIFIER, {16'h0, MODIFIER_RESET});
        rd(REG_STEP_VALUE, 32'h0);
        rd(8'h40, 32'h0);
        wr(REG_ADDRESS_MODIFIER, 16'h8004);
        wr(8'h10, 16'hffff);
        wr(REG_STEP_VALUE, rnd);
        req(PTR_TWO, AM_POST_INC, 16'h0);
        req(PTR_THREE, AM_POST_DEC, 16'h0);
        req(PTR_STACK, AM_POST_OFFSET, 16'h0);
        wr(REG_ADDRESS_MODIFIER, 16'h0004);
        wr(REG_POINTER_BASE, 16'h0800);
        wr(8'h0c, 16'h0800);
        repeat (5) req(PTR_ZERO, AM_POST_INC, 16'h0);
        req(PTR_ZERO, AM_POST_DEC, 16'h0);
        req(PTR_ONE, AM_POST_INC, 16'h0);
        wr(REG_ADDRESS_MODIFIER, 16'h8024);
        wr(REG_STEP_VALUE, 16'h0003);
        wr(REG_POINTER_BASE, 16'h008b);
        wr(8'h0c, 16'h00a4);
        req(PTR_ONE, AM_POST_OFFSET, 16'h0);
        for (int m = 0; m < 7; m++) req(PTR_ZERO, addr_mode_t'(m), 16'hfffb);
        rd(REG_STATUS, 32'h0001_0089);
        wr(REG_ADDRESS_MODIFIER, 16'h3fff);
        wr(REG_POINTER_BASE, 16'h7fff);
        req(PTR_ZERO, AM_POST_INC, 16'h0);
        wr(REG_ADDRESS_MODIFIER, 16'h0001);
        wr(REG_POINTER_BASE, 16'h0001);
        req(PTR_ZERO, AM_POST_INC, 16'h0);
        req(PTR_ZERO, AM_POST_DEC, 16'h0);
        wr(REG_ADDRESS_MODIFIER, MODIFIER_RESET);
        for (int i = 0; i < 24; i++)
        begin
            rnd = lfsr(rnd);
            req(rnd[2:0] % 3'h5, addr_mode_t'(rnd[15:13] % 3'h7), rnd);
        end
        agu_decode_model_inst.issue(3'h5, AM_POST_INC, 16'h0);
        ce_i <= 1'b0;
        agu_decode_model_inst.issue(PTR_ZERO, AM_POST_INC, 16'h0);
        check("ready", 33'h0, {32'h0, hreadyout_o});
        ce_i <= 1'b1;
        rd(REG_POINTER_BASE, {16'h0, ptrs[0]});
        repeat (3) @(posedge clk_sys_i);
        check("pending", 33'h0, 33'(expq.size()));
        test_done();
    end
endmodule
